// *** verilog/efr_cfg.svh ***
// Purpose: constants for the external fault recorder
// Assumes: 100 MHz clk, active-low asynchronous reset
// Notes: widths, bank count, fault status fields and codes shared by the design files
`ifndef EFR_CFG_SVH
`define EFR_CFG_SVH
`define EFR_ADDR_W 48
`define EFR_SYN_W 16
`define EFR_NBANK 8
`define EFR_BANK_W 3
`define EFR_FSR_W 8
`define EFR_FSR_EXT 7
`define EFR_FSR_MULTI 6
`define EFR_PAR_TERM 8'h0A
`define EFR_PAR_EXT 8'h0C
`define EFR_EXT_MASK 8'h80
`endif

// *** verilog/efr_pkg.sv ***
// Purpose: types for the external fault recorder
// Assumes: constants come from efr_cfg.svh
// Notes: none
`include "efr_cfg.svh"
package efr_pkg;
    typedef enum logic [1:0] {
        EFR_SRC_WALK = 2'h0,
        EFR_SRC_DOWN = 2'h1
    } efr_src_e;
    typedef enum logic [1:0] {
        EFR_RESP_OKAY = 2'h0,
        EFR_RESP_EXFAIL = 2'h1,
        EFR_RESP_ABORT = 2'h2,
        EFR_RESP_NONE = 2'h3
    } efr_resp_e;
    typedef enum logic [3:0] {
        EFR_ST_IDLE = 4'h1,
        EFR_ST_ROUTE = 4'h2,
        EFR_ST_WRITE = 4'h4,
        EFR_ST_DONE = 4'h8
    } efr_state_e;
    typedef struct packed {
        logic sync_rec;
        logic bypass;
        logic nested;
        logic is_walk;
        logic is_atop;
        logic is_excl;
        logic sec_known;
        logic secure;
        logic [`EFR_BANK_W-1:0] bank;
        logic [`EFR_BANK_W-1:0] s2_bank;
        logic [`EFR_ADDR_W-1:0] addr;
        logic [`EFR_SYN_W-1:0] syn;
    } efr_fault_s;
endpackage : efr_pkg

// *** verilog/efr_rec_if.sv ***
// Purpose: carries a routed fault record between modules
// Assumes: single clock domain
// Notes: one-cycle write strobes
`timescale 1ns/100ps
`include "efr_cfg.svh"
interface efr_rec_if;
    logic wr_nsg;
    logic wr_sg;
    logic wr_bank;
    logic [`EFR_BANK_W-1:0] bank;
    logic with_syn;
    logic [`EFR_ADDR_W-1:0] addr;
    logic [`EFR_SYN_W-1:0] syn;
    logic repeat_hit;
    modport src (output wr_nsg, wr_sg, wr_bank, bank, with_syn, addr, syn,
        input repeat_hit);
    modport dst (input wr_nsg, wr_sg, wr_bank, bank, with_syn, addr, syn,
        output repeat_hit);
endinterface : efr_rec_if

// *** verilog/efr_bank_store.sv ***
// Purpose: per-bank fault status, address and syndrome storage
// Assumes: clears come from software side ports
// Notes: set wins over clear
`timescale 1ns/100ps
`include "efr_cfg.svh"
module efr_bank_store #(
    parameter int NBANK = `EFR_NBANK
) (
    input wire logic clk,
    input wire logic rst_n,
    efr_rec_if.dst rec,
    input wire logic [NBANK-1:0] clr,
    output logic [NBANK-1:0][`EFR_FSR_W-1:0] fsr,
    output logic [`EFR_ADDR_W-1:0] far_q,
    output logic [`EFR_SYN_W-1:0] syn_q
);
    import efr_pkg::*;
    initial begin
        if (NBANK < 1 || NBANK > (1 << `EFR_BANK_W))
            $error("bank count out of range");
    end
    logic [NBANK-1:0][`EFR_FSR_W-1:0] fsr_r, fsr_nxt;
    logic [NBANK-1:0][`EFR_ADDR_W-1:0] far_r, far_nxt;
    logic [NBANK-1:0][`EFR_SYN_W-1:0] syn_r, syn_nxt;
    // ========================================
    // bank record
    always_comb begin
        fsr_nxt = fsr_r;
        far_nxt = far_r;
        syn_nxt = syn_r;
        for (int i = 0; i < NBANK; i++) begin
            if (clr[i])
                fsr_nxt[i] = '0;
        end
        if (rec.wr_bank) begin
            if (rec.repeat_hit) begin
                fsr_nxt[rec.bank][`EFR_FSR_MULTI] = 1'b1;
            end else begin
                fsr_nxt[rec.bank][`EFR_FSR_EXT] = 1'b1;
                if (rec.with_syn) begin
                    far_nxt[rec.bank] = rec.addr;
                    syn_nxt[rec.bank] = rec.syn;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fsr_r <= '0;
            far_r <= '0;
            syn_r <= '0;
        end else begin
            fsr_r <= fsr_nxt;
            far_r <= far_nxt;
            syn_r <= syn_nxt;
        end
    end
    assign rec.repeat_hit = (fsr_r[rec.bank] != '0);
    assign fsr = fsr_r;
    assign far_q = far_r[rec.bank];
    assign syn_q = syn_r[rec.bank];
    a_repeat_flag: assert property (@(posedge clk) disable iff (!rst_n)
        rec.wr_bank && rec.repeat_hit && !clr[rec.bank]
        |=> fsr_r[$past(rec.bank)][`EFR_FSR_MULTI])
        else $error("repeat fault flag not set");
    a_keep_old: assert property (@(posedge clk) disable iff (!rst_n)
        rec.wr_bank && rec.repeat_hit
        |=> far_r[$past(rec.bank)] == $past(far_r[rec.bank]))
        else $error("repeat fault overwrote address");
endmodule : efr_bank_store

// *** verilog/efr_global_store.sv ***
// Purpose: secure and nonsecure global fault status and syndrome
// Assumes: clears come from software side ports
// Notes: set wins over clear
`timescale 1ns/100ps
`include "efr_cfg.svh"
module efr_global_store (
    input wire logic clk,
    input wire logic rst_n,
    efr_rec_if.dst rec,
    input wire logic ns_origin,
    input wire logic clr_ns,
    input wire logic clr_s,
    output logic [`EFR_FSR_W-1:0] ns_fsr,
    output logic [`EFR_FSR_W-1:0] s_fsr,
    output logic ns_origin_q,
    output logic [`EFR_ADDR_W-1:0] g_far
);
    import efr_pkg::*;
    logic [`EFR_FSR_W-1:0] ns_r, ns_nxt, s_r, s_nxt;
    logic nso_r, nso_nxt;
    logic [`EFR_ADDR_W-1:0] far_r, far_nxt;
    // ========================================
    // global record
    always_comb begin
        ns_nxt = clr_ns ? '0 : ns_r;
        s_nxt = clr_s ? '0 : s_r;
        nso_nxt = nso_r;
        far_nxt = far_r;
        if (rec.wr_nsg)
            ns_nxt[`EFR_FSR_EXT] = 1'b1;
        if (rec.wr_sg) begin
            s_nxt[`EFR_FSR_EXT] = 1'b1;
            nso_nxt = ns_origin;
        end
        if ((rec.wr_nsg || rec.wr_sg) && rec.with_syn)
            far_nxt = rec.addr;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ns_r <= '0;
            s_r <= '0;
            nso_r <= 1'b0;
            far_r <= '0;
        end else begin
            ns_r <= ns_nxt;
            s_r <= s_nxt;
            nso_r <= nso_nxt;
            far_r <= far_nxt;
        end
    end
    assign ns_fsr = ns_r;
    assign s_fsr = s_r;
    assign ns_origin_q = nso_r;
    assign g_far = far_r;
    a_sec_set: assert property (@(posedge clk) disable iff (!rst_n)
        rec.wr_sg |=> s_r[`EFR_FSR_EXT])
        else $error("secure global flag not set");
endmodule : efr_global_store

// *** verilog/efr_recorder.sv ***
// Purpose: routes external aborts to fault status groups
// Assumes: fault inputs are on-chip logic on clk, one-cycle pulses
// Notes: one fault per four cycles; software control bits are plain ports
`timescale 1ns/100ps
`include "efr_cfg.svh"
module efr_recorder #(
    parameter int NBANK = `EFR_NBANK,
    parameter bit TWO_SEC = 1'b1,
    parameter bit UP_ERR_BUS = 1'b1,
    parameter bit ASYNC_GLOBAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flt_valid,
    input wire efr_pkg::efr_fault_s flt,
    input wire logic external_fault_secure_override,
    input wire logic global_fault_abort_enable,
    input wire logic [NBANK-1:0] context_fault_abort_enable,
    input wire logic [NBANK-1:0] context_fault_stall_select,
    input wire logic private_tlb_maintenance,
    input wire logic private_vmid_namespace,
    input wire logic bcast_tlbi,
    input wire logic clr_ns_global,
    input wire logic clr_s_global,
    input wire logic [NBANK-1:0] clr_bank,
    output logic [`EFR_FSR_W-1:0] nonsecure_global_fault_status,
    output logic [`EFR_FSR_W-1:0] secure_global_fault_status,
    output logic secure_global_syndrome_ns,
    output logic [NBANK-1:0][`EFR_FSR_W-1:0] bank_fault_status,
    output logic [`EFR_ADDR_W-1:0] bank_fault_addr,
    output logic [`EFR_SYN_W-1:0] bank_fault_syn,
    output logic [`EFR_ADDR_W-1:0] global_fault_addr,
    output logic resp_valid,
    output efr_pkg::efr_resp_e resp_code,
    output logic resp_stall,
    output logic walk_kill,
    output logic result_valid,
    output logic result_to_bank,
    output logic [`EFR_BANK_W-1:0] result_bank,
    output logic [`EFR_FSR_W-1:0] result_code,
    output logic tlbi_act
);
    import efr_pkg::*;
    initial begin
        if (NBANK < 1 || NBANK > (1 << `EFR_BANK_W))
            $error("bank count out of range");
    end
    efr_rec_if bank_rec ();
    efr_rec_if glob_rec ();
    efr_state_e st_r, st_nxt;
    efr_fault_s f_r, f_nxt;
    logic to_glob, to_sec, rec_on, ovr_eff;
    logic [`EFR_BANK_W-1:0] tgt_bank;
    logic resp_valid_r, resp_valid_nxt, resp_stall_r, resp_stall_nxt;
    efr_resp_e resp_r, resp_nxt;
    logic res_v_r, res_v_nxt, res_b_r, res_b_nxt;
    logic [`EFR_BANK_W-1:0] res_bk_r, res_bk_nxt;
    logic [`EFR_FSR_W-1:0] res_c_r, res_c_nxt;
    logic tlbi_r, tlbi_nxt;
    // override reads zero when faults return upstream
    assign ovr_eff = external_fault_secure_override && !UP_ERR_BUS;
    // ========================================
    // routing decision for the captured fault
    function automatic logic sec_dest(input efr_fault_s f, input logic ovr);
        if (!TWO_SEC)
            return 1'b0;
        if (ovr && (!f.is_walk || !f.sync_rec))
            return 1'b1;
        if (!f.sync_rec)
            return 1'b0;
        return f.sec_known && f.secure;
    endfunction : sec_dest
    always_comb begin
        // async aborts go global under ASYNC_GLOBAL, or client ones when not returned upstream; else only bypass goes global
        to_glob = f_r.bypass;
        if (!f_r.sync_rec && ASYNC_GLOBAL)
            to_glob = 1'b1;
        if (!f_r.is_walk && !UP_ERR_BUS && !f_r.sync_rec)
            to_glob = 1'b1;
        tgt_bank = f_r.nested ? f_r.s2_bank : f_r.bank;
        to_sec = sec_dest(f_r, ovr_eff);
        // client aborts returned upstream are not recorded
        rec_on = f_r.is_walk || !UP_ERR_BUS;
    end
    // ========================================
    // control state
    always_comb begin
        st_nxt = st_r;
        f_nxt = f_r;
        resp_valid_nxt = 1'b0;
        resp_nxt = resp_r;
        resp_stall_nxt = resp_stall_r;
        res_v_nxt = 1'b0;
        res_b_nxt = res_b_r;
        res_bk_nxt = res_bk_r;
        res_c_nxt = res_c_r;
        bank_rec.wr_bank = 1'b0;
        glob_rec.wr_nsg = 1'b0;
        glob_rec.wr_sg = 1'b0;
        unique case (st_r)
            EFR_ST_IDLE: begin
                if (flt_valid) begin
                    f_nxt = flt;
                    st_nxt = EFR_ST_ROUTE;
                end
            end
            EFR_ST_ROUTE: begin
                st_nxt = EFR_ST_WRITE;
            end
            EFR_ST_WRITE: begin
                if (f_r.is_atop && !f_r.nested) begin
                    res_v_nxt = 1'b1;
                    res_b_nxt = !f_r.bypass;
                    res_bk_nxt = f_r.bank;
                    res_c_nxt = `EFR_PAR_EXT;
                end else if (f_r.is_atop) begin
                    bank_rec.wr_bank = 1'b1;
                    res_v_nxt = 1'b1;
                    res_b_nxt = 1'b1;
                    res_bk_nxt = f_r.bank;
                    res_c_nxt = `EFR_PAR_TERM;
                end else if (rec_on) begin
                    bank_rec.wr_bank = !to_glob;
                    glob_rec.wr_nsg = to_glob && !to_sec;
                    glob_rec.wr_sg = to_glob && to_sec;
                end
                if (!f_r.is_atop) begin
                    resp_valid_nxt = 1'b1;
                    if (f_r.bypass || f_r.is_walk && f_r.bypass)
                        resp_nxt = global_fault_abort_enable
                            ? EFR_RESP_ABORT : EFR_RESP_NONE;
                    else
                        resp_nxt = context_fault_abort_enable[f_r.bank]
                            ? EFR_RESP_ABORT : EFR_RESP_NONE;
                    if (resp_nxt == EFR_RESP_NONE)
                        resp_nxt = f_r.is_excl ? EFR_RESP_EXFAIL
                            : EFR_RESP_OKAY;
                    resp_stall_nxt = !f_r.bypass
                        && context_fault_stall_select[f_r.bank];
                end
                st_nxt = EFR_ST_DONE;
            end
            EFR_ST_DONE: begin
                st_nxt = EFR_ST_IDLE;
            end
            default: st_nxt = EFR_ST_IDLE;
        endcase
        // broadcast maintenance is ignored under private namespaces
        tlbi_nxt = bcast_tlbi && !private_tlb_maintenance
            && !private_vmid_namespace;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= EFR_ST_IDLE;
            f_r <= '0;
            resp_valid_r <= 1'b0;
            resp_r <= EFR_RESP_OKAY;
            resp_stall_r <= 1'b0;
            res_v_r <= 1'b0;
            res_b_r <= 1'b0;
            res_bk_r <= '0;
            res_c_r <= '0;
            tlbi_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            f_r <= f_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_r <= resp_nxt;
            resp_stall_r <= resp_stall_nxt;
            res_v_r <= res_v_nxt;
            res_b_r <= res_b_nxt;
            res_bk_r <= res_bk_nxt;
            res_c_r <= res_c_nxt;
            tlbi_r <= tlbi_nxt;
        end
    end
    // ========================================
    // record payloads
    assign bank_rec.bank = tgt_bank;
    assign bank_rec.with_syn = f_r.sync_rec;
    assign bank_rec.addr = f_r.addr;
    assign bank_rec.syn = f_r.syn;
    assign bank_rec.wr_nsg = 1'b0;
    assign bank_rec.wr_sg = 1'b0;
    assign glob_rec.bank = '0;
    assign glob_rec.with_syn = f_r.sync_rec;
    assign glob_rec.addr = f_r.addr;
    assign glob_rec.syn = f_r.syn;
    assign glob_rec.wr_bank = 1'b0;
    assign glob_rec.repeat_hit = 1'b0;
    efr_bank_store #(.NBANK(NBANK)) u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .rec(bank_rec),
        .clr(clr_bank),
        .fsr(bank_fault_status),
        .far_q(bank_fault_addr),
        .syn_q(bank_fault_syn)
    );
    logic [`EFR_FSR_W-1:0] ns_raw, s_raw;
    logic nso_raw;
    efr_global_store u_glob (
        .clk(clk),
        .rst_n(rst_n),
        .rec(glob_rec),
        .ns_origin(!f_r.secure),
        .clr_ns(clr_ns_global),
        .clr_s(clr_s_global),
        .ns_fsr(ns_raw),
        .s_fsr(s_raw),
        .ns_origin_q(nso_raw),
        .g_far(global_fault_addr)
    );
    // global fault flags read zero when faults are returned upstream
    assign nonsecure_global_fault_status = UP_ERR_BUS
        ? (ns_raw & ~`EFR_EXT_MASK) : ns_raw;
    assign secure_global_fault_status = UP_ERR_BUS
        ? (s_raw & ~`EFR_EXT_MASK) : s_raw;
    assign secure_global_syndrome_ns = UP_ERR_BUS ? 1'b0 : nso_raw;
    assign resp_valid = resp_valid_r;
    assign resp_code = resp_r;
    assign resp_stall = resp_stall_r;
    // aborted walk data never becomes a tlb fill, and becomes a result only for a translation op
    assign walk_kill = (st_r == EFR_ST_WRITE) && f_r.is_walk;
    assign result_valid = res_v_r;
    assign result_to_bank = res_b_r;
    assign result_bank = res_bk_r;
    assign result_code = res_c_r;
    assign tlbi_act = tlbi_r;
    // ========================================
    // checks
    sequence s_take;
        st_r == EFR_ST_IDLE && flt_valid;
    endsequence
    sequence s_write;
        st_r == EFR_ST_WRITE;
    endsequence
    a_fault_walk: assert property (@(posedge clk) disable iff (!rst_n)
        s_take |-> ##2 s_write)
        else $error("fault not routed two cycles after capture");
    a_walk_rec: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and f_r.is_walk && !f_r.is_atop
        |-> bank_rec.wr_bank || glob_rec.wr_nsg || glob_rec.wr_sg)
        else $error("walk abort not recorded");
    a_nested_s2: assert property (@(posedge clk) disable iff (!rst_n)
        bank_rec.wr_bank && f_r.nested |-> bank_rec.bank == f_r.s2_bank)
        else $error("nested abort not in stage 2 bank");
    a_override: assert property (@(posedge clk) disable iff (!rst_n)
        TWO_SEC && external_fault_secure_override && !f_r.is_walk
        && glob_rec.wr_nsg |-> 1'b0)
        else $error("override ignored");
    a_bypass_glob: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and f_r.bypass && rec_on && !f_r.is_atop
        |-> !bank_rec.wr_bank)
        else $error("bypass abort went to bank");
    a_term_code: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and f_r.is_atop && f_r.nested
        |=> result_valid && result_code == `EFR_PAR_TERM)
        else $error("missing terminated status");
    a_excl_fail: assert property (@(posedge clk) disable iff (!rst_n)
        resp_valid && f_r.is_excl && resp_code != EFR_RESP_ABORT
        |-> resp_code == EFR_RESP_EXFAIL)
        else $error("exclusive not reported as failed");
    a_tlbi_priv: assert property (@(posedge clk) disable iff (!rst_n)
        $past(private_tlb_maintenance) || $past(private_vmid_namespace)
        |-> !tlbi_act)
        else $error("broadcast acted under private maintenance");
    a_async_nosyn: assert property (@(posedge clk) disable iff (!rst_n)
        bank_rec.wr_bank && !f_r.sync_rec |-> !bank_rec.with_syn)
        else $error("async abort wrote syndrome");
    a_tlbi_ok: assert property (@(posedge clk) disable iff (!rst_n)
        bcast_tlbi && !private_tlb_maintenance && !private_vmid_namespace
        |=> tlbi_act)
        else $error("allowed broadcast not acted on");
    a_stall_sel: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and !f_r.is_atop && !f_r.bypass
        |=> resp_stall == $past(context_fault_stall_select[f_r.bank]))
        else $error("stall select not applied");
    a_ctx_abort: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and !f_r.is_atop && !f_r.bypass
        && context_fault_abort_enable[f_r.bank]
        |=> resp_valid && resp_code == EFR_RESP_ABORT)
        else $error("context fault not reported as abort");
    a_glob_abort: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and !f_r.is_atop && f_r.bypass && global_fault_abort_enable
        |=> resp_valid && resp_code == EFR_RESP_ABORT)
        else $error("global fault not reported as abort");
    a_kill_nores: assert property (@(posedge clk) disable iff (!rst_n)
        walk_kill && !f_r.is_atop |=> !result_valid)
        else $error("aborted walk produced a result");
    a_op_noresp: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and f_r.is_atop |=> !resp_valid)
        else $error("translation op answered upstream");
    a_async_glob: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and ASYNC_GLOBAL && !f_r.sync_rec && !f_r.is_atop
        |-> !bank_rec.wr_bank)
        else $error("async abort recorded in a bank");
    a_sync_bank: assert property (@(posedge clk) disable iff (!rst_n)
        s_write and rec_on && f_r.sync_rec && !f_r.bypass && !f_r.is_atop
        |-> bank_rec.wr_bank && !glob_rec.wr_nsg && !glob_rec.wr_sg)
        else $error("sync translated abort not in its bank");
    a_sec_state: assert property (@(posedge clk) disable iff (!rst_n)
        glob_rec.wr_sg && f_r.sync_rec && !ovr_eff
        |-> f_r.sec_known && f_r.secure)
        else $error("secure group chosen without secure state");
endmodule : efr_recorder

// *** verif/efr_far_model.sv ***
// Purpose: far-side source of aborted walk and downstream transactions
// Assumes: clk comes from the bench
// Notes: descriptor is zero until the first offer and inverted after each offer
`timescale 1ns/100ps
module efr_far_model (
    input wire logic clk,
    output logic flt_valid,
    output efr_pkg::efr_fault_s flt
);
    import efr_pkg::*;
    initial begin
        flt_valid = 1'b0;
        flt = '0;
    end
    // one-cycle offer, then the descriptor no longer holds its value
    task automatic fire(input efr_fault_s f);
        @(negedge clk);
        flt_valid = 1'b1;
        flt = f;
        @(negedge clk);
        flt_valid = 1'b0;
        flt = ~f;
    endtask : fire
endmodule : efr_far_model

// *** verif/external_fault_recorder_tb_top.sv ***
// Purpose: self-checking bench for the external fault recorder
// Assumes: design assertions run alongside
// Notes: uut records all aborts except non-nested translation op aborts, uut_ret returns downstream aborts
`timescale 1ns/100ps
`include "efr_cfg.svh"
module external_fault_recorder_tb_top;
    import efr_pkg::*;
    // =====================
    // stimulus and wiring
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ovr = 1'b0, g_abt_en = 1'b1, priv_tlb = 1'b0, vpn = 1'b0;
    logic bti = 1'b0, cns = 1'b0, cs = 1'b0;
    logic [7:0] c_abt_en = 8'hFF, stall_sel = 8'h00, cb = 8'h00;
    int bad_count = 0, samples_checked = 0;
    logic c_kill, c_res, c_stall, c_rv, c_urv;
    efr_resp_e c_rc, c_urc, exp_rc, r_rc, u_rc;
    logic flt_valid;
    efr_fault_s flt;
    wire [`EFR_FSR_W-1:0] nsg, sg, r_ns, r_sg, rcd;
    wire [7:0][`EFR_FSR_W-1:0] bfs;
    wire [`EFR_ADDR_W-1:0] bfa, gfa;
    wire [`EFR_SYN_W-1:0] bsy;
    wire [`EFR_BANK_W-1:0] rbk;
    wire wk, resv, stl, rtb, tla, r_syn, r_rv, u_syn, u_rv;
    always #5 clk = ~clk;
    efr_far_model partner (.clk(clk), .flt_valid(flt_valid), .flt(flt));
    efr_recorder #(.UP_ERR_BUS(1'b0)) uut (
        .clk(clk), .rst_n(rst_n), .flt_valid(flt_valid), .flt(flt),
        .external_fault_secure_override(ovr),
        .global_fault_abort_enable(g_abt_en),
        .context_fault_abort_enable(c_abt_en),
        .context_fault_stall_select(stall_sel),
        .private_tlb_maintenance(priv_tlb), .private_vmid_namespace(vpn),
        .bcast_tlbi(bti), .clr_ns_global(cns), .clr_s_global(cs),
        .clr_bank(cb), .nonsecure_global_fault_status(nsg),
        .secure_global_fault_status(sg), .secure_global_syndrome_ns(u_syn),
        .bank_fault_status(bfs), .bank_fault_addr(bfa), .bank_fault_syn(bsy),
        .global_fault_addr(gfa), .resp_valid(u_rv), .resp_code(u_rc),
        .resp_stall(stl),
        .walk_kill(wk), .result_valid(resv), .result_to_bank(rtb),
        .result_bank(rbk), .result_code(rcd), .tlbi_act(tla)
    );
    efr_recorder uut_ret (
        .clk(clk), .rst_n(rst_n), .flt_valid(flt_valid), .flt(flt),
        .external_fault_secure_override(ovr),
        .global_fault_abort_enable(g_abt_en),
        .context_fault_abort_enable(c_abt_en),
        .context_fault_stall_select(stall_sel),
        .private_tlb_maintenance(priv_tlb), .private_vmid_namespace(vpn),
        .bcast_tlbi(bti), .clr_ns_global(cns), .clr_s_global(cs),
        .clr_bank(cb), .nonsecure_global_fault_status(r_ns),
        .secure_global_fault_status(r_sg), .secure_global_syndrome_ns(r_syn),
        .bank_fault_status(), .bank_fault_addr(), .bank_fault_syn(),
        .global_fault_addr(), .resp_valid(r_rv), .resp_code(r_rc),
        .resp_stall(), .walk_kill(), .result_valid(), .result_to_bank(),
        .result_bank(), .result_code(), .tlbi_act()
    );
    // =====================
    // tasks
    task automatic chk(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // flags: sync bypass nested walk op excl known secure, msb first
    function automatic efr_fault_s mk(input logic [7:0] fl,
        input logic [2:0] b, input logic [2:0] s2);
        efr_fault_s r;
        {r.sync_rec, r.bypass, r.nested, r.is_walk, r.is_atop, r.is_excl,
            r.sec_known, r.secure} = fl;
        r.bank = b;
        r.s2_bank = s2;
        r.addr = {45'h0_1234_5678_9A, b};
        r.syn = {13'h1F0, b};
        return r;
    endfunction : mk
    // offer one fault, sample the kill in WRITE and answers a cycle later
    task automatic run(input efr_fault_s x);
        partner.fire(x);
        @(negedge clk);
        c_kill = wk;
        @(negedge clk);
        c_res = resv;
        c_stall = stl;
        c_rv = r_rv;
        c_rc = r_rc;
        c_urv = u_rv;
        c_urc = u_rc;
        repeat (2) @(negedge clk);
    endtask : run
    task automatic clear();
        cns = 1'b1;
        cs = 1'b1;
        cb = 8'hFF;
        @(negedge clk);
        cns = 1'b0;
        cs = 1'b0;
        cb = 8'h00;
    endtask : clear
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // =====================
    // tests
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int s = 0; s < 2; s++) begin
            run(mk(s[0] ? 8'hD3 : 8'hD2, 3'h0, 3'h0));
            chk("walk_kill", 1, c_kill);
            chk("walk_s_global", s, sg[7]);
            chk("walk_ns_global", 1 - s, nsg[7]);
            chk("glob_addr", {45'h0_1234_5678_9A, 3'h0}, gfa);
            chk("ret_walk", 0, r_ns | r_sg);
            clear();
        end
        stall_sel = 8'h08;
        run(mk(8'h92, 3'h3, 3'h0));
        chk("bank3_ef", 1, bfs[3][7]);
        chk("bank_addr", {45'h0_1234_5678_9A, 3'h3}, bfa);
        chk("bank_syn", {13'h1F0, 3'h3}, bsy);
        chk("stall", 1, c_stall);
        clear();
        run(mk(8'hB2, 3'h1, 3'h5));
        chk("s2_bank_ef", 1, bfs[5][7]);
        chk("s1_bank", 0, bfs[1]);
        run(mk(8'hB2, 3'h2, 3'h5));
        chk("repeat_flag", 1, bfs[5][6]);
        chk("shared_valid", 1, c_urv);
        chk("shared_resp", EFR_RESP_ABORT, c_urc);
        chk("kept_addr", {45'h0_1234_5678_9A, 3'h1}, bfa);
        clear();
        for (int o = 0; o < 2; o++) begin
            ovr = o[0];
            run(mk(8'h10, 3'h2, 3'h0));
            chk("async_ns", 1 - o, nsg[7]);
            chk("async_s", o, sg[7]);
            chk("async_bank", 0, bfs[2]);
            clear();
        end
        for (int i = 0; i < 3; i++) begin
            ovr = (i == 2);
            run(mk(i == 0 ? 8'hC3 : i == 1 ? 8'hC1 : 8'hC2, 3'h0, 3'h0));
            chk("down_s", i != 1, sg[7]);
            chk("down_ns", i == 1, nsg[7]);
            chk("origin_ns", i == 2, u_syn);
            chk("ret_ns", 0, r_ns);
            chk("ret_s", 0, r_sg);
            chk("ret_origin", 0, r_syn);
            chk("ret_resp", EFR_RESP_ABORT, c_rc);
            clear();
        end
        ovr = 1'b0;
        for (int i = 0; i < 3; i++) begin
            g_abt_en = (i != 0);
            c_abt_en = (i == 1) ? 8'hEF : 8'hFF;
            exp_rc = (i == 2) ? EFR_RESP_ABORT : EFR_RESP_EXFAIL;
            run(mk(i == 0 ? 8'hC6 : 8'h86, 3'h4, 3'h0));
            chk("excl_valid", 1, c_rv);
            chk("excl_resp", exp_rc, c_rc);
        end
        chk("no_err_bus_bank", 1, bfs[4][7]);
        clear();
        run(mk(8'h98, 3'h4, 3'h0));
        chk("op_result", 1, c_res);
        chk("op_code", `EFR_PAR_EXT, rcd);
        chk("op_no_status", 0, bfs[4]);
        run(mk(8'hB8, 3'h1, 3'h6));
        chk("op_s2_ef", 1, bfs[6][7]);
        chk("op_term", `EFR_PAR_TERM, rcd);
        chk("op_bank", {1'b1, 3'h1}, {rtb, rbk});
        for (int p = 0; p < 4; p++) begin
            {priv_tlb, vpn} = p[1:0];
            bti = 1'b1;
            @(negedge clk);
            bti = 1'b0;
            chk("tlbi_act", p == 0, tla);
            @(negedge clk);
        end
        give_verdict();
    end
    // the tests need well under 3000 ns
    initial begin
        #20000;
        bad_count++;
        give_verdict();
    end
endmodule : external_fault_recorder_tb_top
